// file: verilog/rdc_pkg.sv
// Functional notes
// - floating address straps answer at target 0x12
// - each receiver equalization settable through registers
// - override bit selects strap or register equalization
// - orientation bit: 0 normal, 1 flipped, resets 0
// - datapath enable 0 disables all receivers/transmitters
// - general register at 0x0a, resets to 0x01
// - set-type fields: write one sets, zero ignored
// - clear-type fields: write one clears, zero ignored
// - update-type fields track hardware, reads current value
`default_nettype none
package rdc_pkg;
  // strap pin levels
  typedef enum logic [1:0] {
    RDC_LVL_LOW,
    RDC_LVL_FLOAT,
    RDC_LVL_HIGH
  } rdc_level_t;

  // i2c target address base, floating straps give 0x12
  localparam logic [6:0] RDC_ADDR_BASE = 7'h12;
  localparam logic [6:0] RDC_ADDR_STEP = 7'h01;

  // register offsets
  localparam logic [7:0] RDC_OFS_GENERAL = 8'h0a;
  localparam logic [7:0] RDC_OFS_EQ_RX   = 8'h20;
  localparam logic [7:0] RDC_OFS_EQ_SS   = 8'h21;

  // general register fields
  localparam int unsigned RDC_BIT_DP_EN   = 0;
  localparam int unsigned RDC_BIT_RSV1    = 1;
  localparam int unsigned RDC_BIT_FLIP    = 2;
  localparam int unsigned RDC_BIT_RSV3    = 3;
  localparam int unsigned RDC_BIT_EQ_SRC  = 4;
  localparam logic [7:0]  RDC_GEN_RESET   = 8'h01;
  localparam logic [7:0]  RDC_GEN_WMASK   = 8'h1f;
  localparam logic [7:0]  RDC_SS_WMASK    = 8'h0f;

  // equalization codes from straps or registers, one 4-bit code per receiver
  typedef struct packed {
    logic [3:0] rx2;
    logic [3:0] rx1;
    logic [3:0] ss;
  } rdc_eq_t;

  // controls handed to the analog datapath
  typedef struct packed {
    logic    datapath_en;
    logic    flip;
    rdc_eq_t eq;
  } rdc_ctl_t;
endpackage : rdc_pkg
`default_nettype wire

// file: verilog/rdc_i2c_target.sv
`timescale 1ns/1ps
`default_nettype none
// byte-level i2c target: start/stop, address match, offset, data
module rdc_i2c_target
  import rdc_pkg::*;
(
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       resetn,
  // synchronised bus lines
  input  wire logic       scl,
  input  wire logic       sda,
  output logic            sda_oe,
  // own address
  input  wire logic [6:0] own_addr,
  // register access
  output logic            wr_stb,
  output logic [7:0]      wr_data,
  output logic [7:0]      reg_addr,
  output logic            rd_stb,
  input  wire logic [7:0] rd_data
);
  typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_OFS, ST_WDATA, ST_RDATA, ST_WAIT} rdc_st_t;

  rdc_st_t    st, next_st;
  logic       scl_q, sda_q;
  logic [7:0] sh, next_sh;
  logic [3:0] cnt, next_cnt;
  logic       ack, next_ack;
  logic       rd_mode, next_rd_mode;
  logic [7:0] ptr, next_ptr;
  logic       next_wr_stb, next_rd_stb;
  logic       next_sda_oe;
  logic       rise, fall, start_c, stop_c;

  // bus event detection
  assign rise    = scl & ~scl_q;
  assign fall    = ~scl & scl_q;
  assign start_c = scl & scl_q & sda_q & ~sda;
  assign stop_c  = scl & scl_q & ~sda_q & sda;
  assign reg_addr = ptr;
  assign wr_data  = sh;

  // next-state logic
  always_comb begin
    next_st = st; next_sh = sh; next_cnt = cnt; next_ack = ack;
    next_rd_mode = rd_mode; next_ptr = ptr;
    next_wr_stb = 1'b0; next_rd_stb = 1'b0; next_sda_oe = sda_oe;
    // step the pointer only after the write strobe has used it
    if (wr_stb) next_ptr = ptr + 8'h01;
    if (start_c) begin
      next_st = ST_ADDR; next_cnt = 4'h0; next_ack = 1'b0; next_sda_oe = 1'b0;
    end else if (stop_c) begin
      next_st = ST_IDLE; next_sda_oe = 1'b0;
    end else if (st != ST_IDLE && st != ST_WAIT) begin
      if (rise && !ack && !(st == ST_RDATA)) begin
        next_sh  = {sh[6:0], sda};
        next_cnt = cnt + 4'h1;
      end
      if (rise && st == ST_RDATA && !ack) next_cnt = cnt + 4'h1;
      if (rise && st == ST_RDATA && ack) begin
        if (sda) next_st = ST_WAIT; // nack ends data
        else next_rd_stb = 1'b1;
      end
      if (fall) begin
        if (ack) begin
          next_ack = 1'b0; next_cnt = 4'h0; next_sda_oe = 1'b0;
          if (st == ST_RDATA) next_sda_oe = ~rd_data[7];
        end else if (cnt == 4'h8) begin
          next_ack = 1'b1;
          next_sda_oe = 1'b1;
          case (st)
            ST_ADDR: begin
              if (sh[7:1] == own_addr) begin
                next_rd_mode = sh[0];
                next_st = sh[0] ? ST_RDATA : ST_OFS;
                if (sh[0]) next_sh = rd_data;
              end else begin
                next_st = ST_WAIT; next_sda_oe = 1'b0;
              end
            end
            ST_OFS: begin
              next_ptr = sh; next_st = ST_WDATA;
            end
            ST_WDATA: begin
              next_wr_stb = 1'b1; // applied at byte end
            end
            ST_RDATA: begin
              next_sda_oe = 1'b0; // release for controller ack
              next_ptr = ptr + 8'h01;
            end
            default: next_st = ST_IDLE;
          endcase
        end else if (st == ST_RDATA) begin
          next_sda_oe = ~sh[3'(7 - cnt[2:0])];
        end
      end
      if (next_rd_stb) next_sh = rd_data;
    end
  end

  // state registers
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      st <= ST_IDLE; scl_q <= 1'b1; sda_q <= 1'b1; sh <= 8'h00; cnt <= 4'h0;
      ack <= 1'b0; rd_mode <= 1'b0; ptr <= 8'h00; wr_stb <= 1'b0;
      rd_stb <= 1'b0; sda_oe <= 1'b0;
    end else begin
      st <= next_st; scl_q <= scl; sda_q <= sda; sh <= next_sh; cnt <= next_cnt;
      ack <= next_ack; rd_mode <= next_rd_mode; ptr <= next_ptr;
      wr_stb <= next_wr_stb; rd_stb <= next_rd_stb; sda_oe <= next_sda_oe;
    end
  end
endmodule : rdc_i2c_target
`default_nettype wire

// file: verilog/rdc_general_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
// general control register bank behind the i2c target port
module rdc_general_ctrl
  import rdc_pkg::*;
(
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       resetn,
  // i2c pins
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  // address straps, decoded levels
  input  wire rdc_level_t addr_strap_hi,
  input  wire rdc_level_t addr_strap_lo,
  // equalization strap pins
  input  wire logic [1:0] post_channel_eq_pins,
  input  wire logic [1:0] pre_channel_eq_pins,
  // datapath controls
  output rdc_ctl_t        ctl
);
  logic [1:0] scl_s, sda_s;
  logic [1:0] post_s, post_m, pre_s, pre_m;
  logic [7:0] general_control, next_general_control;
  logic [7:0] eq_rx, next_eq_rx;
  logic [3:0] eq_ss, next_eq_ss;
  logic       wr_stb, rd_stb;
  logic [7:0] wr_data, reg_addr, rd_data;
  logic [6:0] own_addr;
  rdc_level_t hi_m, hi_s, lo_m, lo_s;
  rdc_ctl_t   next_ctl;

  // two-flop synchronisers for pins
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      scl_s <= 2'h3; sda_s <= 2'h3; post_m <= 2'h0; post_s <= 2'h0;
      pre_m <= 2'h0; pre_s <= 2'h0;
      hi_m <= RDC_LVL_FLOAT; hi_s <= RDC_LVL_FLOAT;
      lo_m <= RDC_LVL_FLOAT; lo_s <= RDC_LVL_FLOAT;
    end else begin
      scl_s <= {scl_s[0], scl_in}; sda_s <= {sda_s[0], sda_in};
      post_m <= post_channel_eq_pins; post_s <= post_m;
      pre_m <= pre_channel_eq_pins; pre_s <= pre_m;
      hi_m <= addr_strap_hi; hi_s <= hi_m;
      lo_m <= addr_strap_lo; lo_s <= lo_m;
    end
  end

  // address from strap levels, floating pair gives base
  always_comb begin
    own_addr = RDC_ADDR_BASE
      + 7'(3 * (int'(hi_s) - int'(RDC_LVL_FLOAT)))
      + 7'(int'(lo_s) - int'(RDC_LVL_FLOAT));
  end

  rdc_i2c_target u_tgt (
    .core_clk (core_clk),
    .resetn   (resetn),
    .scl      (scl_s[1]),
    .sda      (sda_s[1]),
    .sda_oe   (sda_oe),
    .own_addr (own_addr),
    .wr_stb   (wr_stb),
    .wr_data  (wr_data),
    .reg_addr (reg_addr),
    .rd_stb   (rd_stb),
    .rd_data  (rd_data)
  );
  assign sda_out = 1'b0; // open drain

  // register writes; equalization fields follow straps unless overridden
  always_comb begin
    next_general_control = general_control;
    next_eq_rx = eq_rx;
    next_eq_ss = eq_ss;
    if (wr_stb && reg_addr == RDC_OFS_GENERAL)
      next_general_control = wr_data & RDC_GEN_WMASK;
    if (!general_control[RDC_BIT_EQ_SRC]) begin
      next_eq_rx = {2'b00, post_s, 2'b00, post_s}; // hardware update
      next_eq_ss = {2'b00, pre_s};
    end else begin
      if (wr_stb && reg_addr == RDC_OFS_EQ_RX) next_eq_rx = wr_data;
      if (wr_stb && reg_addr == RDC_OFS_EQ_SS) next_eq_ss = wr_data[3:0] & RDC_SS_WMASK[3:0];
    end
  end

  // read mux; no set or clear type fields exist here
  always_comb begin
    if (reg_addr == RDC_OFS_GENERAL) rd_data = general_control;
    else if (reg_addr == RDC_OFS_EQ_RX) rd_data = eq_rx;
    else if (reg_addr == RDC_OFS_EQ_SS) rd_data = {4'h0, eq_ss};
    else rd_data = 8'h00;
  end

  // datapath controls from live register state
  always_comb begin
    next_ctl.datapath_en = general_control[RDC_BIT_DP_EN];
    next_ctl.flip        = general_control[RDC_BIT_FLIP];
    next_ctl.eq.rx2      = eq_rx[7:4];
    next_ctl.eq.rx1      = eq_rx[3:0];
    next_ctl.eq.ss       = eq_ss;
  end

  // registers
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      general_control <= RDC_GEN_RESET;
      eq_rx <= 8'h00;
      eq_ss <= 4'h0;
      ctl   <= '0;
    end else begin
      general_control <= next_general_control;
      eq_rx <= next_eq_rx;
      eq_ss <= next_eq_ss;
      ctl   <= next_ctl;
    end
  end
endmodule : rdc_general_ctrl
`default_nettype wire

// file: verification/rdc_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// bus pin and control timing checks
module rdc_monitor
  import rdc_pkg::*;
(
  // clock, reset, pins
  input wire logic     core_clk,
  input wire logic     resetn,
  input wire logic     scl_in,
  input wire logic     sda_out,
  input wire logic     sda_oe,
  input wire rdc_ctl_t ctl
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  // pin behaviour and control timing
  property p_low; sda_out == 1'b0; endproperty
  a_low: assert property (p_low) else $error("sda_out high");
  property p_rst; $rose(resetn) |-> ##1 ctl.datapath_en && !ctl.flip; endproperty
  a_rst: assert property (p_rst) else $error("reset value");
  property p_roe; $rose(resetn) |-> (!sda_oe)[*2]; endproperty
  a_roe: assert property (p_roe) else $error("oe after reset");
  property p_up; $rose(sda_oe) |-> !scl_in; endproperty
  a_up: assert property (p_up) else $error("oe rose, scl high");
  property p_dn; $fell(sda_oe) |-> !scl_in; endproperty
  a_dn: assert property (p_dn) else $error("oe fell, scl high");
  property p_hold; $rose(sda_oe) |-> sda_oe[*3]; endproperty
  a_hold: assert property (p_hold) else $error("oe glitch");
  property p_hi; scl_in && $past(scl_in) |-> $stable(sda_oe); endproperty
  a_hi: assert property (p_hi) else $error("oe moved, scl high");
  property p_upd; $past(resetn, 2) && $changed({ctl.datapath_en, ctl.flip}) |-> !scl_in;
  endproperty
  a_upd: assert property (p_upd) else $error("ctl moved, scl high");
  // scenarios reached
  c_off: cover property ($fell(ctl.datapath_en));
  c_flip: cover property ($rose(ctl.flip));
  c_ack: cover property ($rose(sda_oe));
endmodule : rdc_monitor
bind rdc_general_ctrl rdc_monitor mon_u (.core_clk(core_clk), .resetn(resetn),
  .scl_in(scl_in), .sda_out(sda_out), .sda_oe(sda_oe), .ctl(ctl));
`default_nettype wire

// file: verification/rdc_i2c_host.sv
`timescale 1ns/1ps
`default_nettype none
// bus host, open-drain data, scl idles high
module rdc_i2c_host (
  // clock and bus
  input  wire logic core_clk,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_low
);
  initial scl = 1'b1;
  initial sda_low = 1'b0;
  // quarter of a bus bit
  task automatic q();
    repeat (8) @(posedge core_clk);
  endtask : q
  // start (0,1,0), stop (1,0,1) or bit; sampled mid high phase
  task automatic step(input logic a, input logic b, input logic c, output logic r);
    sda_low <= a;
    q();
    scl <= 1'b1;
    q();
    r = sda;
    sda_low <= b;
    q();
    scl <= c;
    q();
  endtask : step
  // byte msb first, then acknowledge slot
  task automatic xfer(input logic [7:0] tx, input logic ak, output logic [7:0] rx,
                      output logic ai);
    for (int i = 7; i >= 0; i--)
      step(!tx[i], !tx[i], 1'b0, rx[i]);
    step(!ak, !ak, 1'b0, ai);
  endtask : xfer
endmodule : rdc_i2c_host
`default_nettype wire

// file: verification/rdc_general_ctrl_test.sv
`timescale 1ns/1ps
`default_nettype none
// general control register bench
module rdc_general_ctrl_test import rdc_pkg::*;;
  logic       core_clk, resetn, scl, sda_low, sda_oe, junk;
  wire        sda;
  rdc_level_t s_hi, s_lo;
  logic [1:0] post, pre;
  rdc_ctl_t   ctl;
  logic [6:0] dev;
  int         mismatches, num_checks;
  // open-drain data with pull-up
  assign sda = !(sda_low || sda_oe);
  rdc_general_ctrl dut_u (.core_clk(core_clk), .resetn(resetn), .scl_in(scl),
    .sda_in(sda), .sda_out(), .sda_oe(sda_oe), .addr_strap_hi(s_hi),
    .addr_strap_lo(s_lo), .post_channel_eq_pins(post), .pre_channel_eq_pins(pre), .ctl(ctl));
  rdc_i2c_host host_u (.core_clk(core_clk), .sda(sda), .scl(scl), .sda_low(sda_low));
  always #25 core_clk = ~core_clk;
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : finish_test
  // one byte out, acknowledge judged
  task automatic put(input logic [7:0] b, input logic nak);
    logic [7:0] r;
    logic       a;
    host_u.xfer(b, 1'b1, r, a);
    chk("ack", {15'h0, nak}, {15'h0, a});
  endtask : put
  task automatic wr(input logic [7:0] o, input logic [7:0] d);
    host_u.step(1'b0, 1'b1, 1'b0, junk);
    put({dev, 1'b0}, 1'b0);
    put(o, 1'b0);
    put(d, 1'b0);
    host_u.step(1'b1, 1'b0, 1'b1, junk);
  endtask : wr
  // offset, repeated start, one byte with final nack
  task automatic rd(input logic [7:0] o, input logic [7:0] e);
    logic [7:0] r;
    host_u.step(1'b0, 1'b1, 1'b0, junk);
    put({dev, 1'b0}, 1'b0);
    put(o, 1'b0);
    host_u.step(1'b0, 1'b1, 1'b0, junk);
    put({dev, 1'b1}, 1'b0);
    host_u.xfer(8'hff, 1'b1, r, junk);
    host_u.step(1'b1, 1'b0, 1'b1, junk);
    chk("read", {8'h0, e}, {8'h0, r});
  endtask : rd
  task automatic do_reset();
    resetn <= 1'b0;
    repeat (10) @(posedge core_clk);
    resetn <= 1'b1;
    repeat (5) @(posedge core_clk);
  endtask : do_reset
  task automatic t_reset();
    rd(RDC_OFS_GENERAL, RDC_GEN_RESET);
    chk("dp_flip", 16'h2, {14'h0, ctl.datapath_en, ctl.flip});
    $display("t_reset done");
  endtask : t_reset
  task automatic t_general();
    wr(RDC_OFS_GENERAL, 8'hff);
    chk("dp_flip", 16'h3, {14'h0, ctl.datapath_en, ctl.flip});
    rd(RDC_OFS_GENERAL, 8'h1f);
    wr(RDC_OFS_GENERAL, 8'h04);
    chk("dp_flip", 16'h1, {14'h0, ctl.datapath_en, ctl.flip});
    $display("t_general done");
  endtask : t_general
  task automatic t_eq();
    post <= 2'b10;
    pre <= 2'b01;
    wr(RDC_OFS_EQ_RX, 8'h5a);
    chk("eq_pins", 16'h221, {4'h0, ctl.eq});
    rd(RDC_OFS_EQ_RX, 8'h22);
    wr(RDC_OFS_GENERAL, 8'h11);
    wr(RDC_OFS_EQ_RX, 8'h5a);
    wr(RDC_OFS_EQ_SS, 8'hfc);
    chk("eq_regs", 16'h5ac, {4'h0, ctl.eq});
    rd(RDC_OFS_EQ_SS, 8'h0c);
    $display("t_eq done");
  endtask : t_eq
  task automatic t_addr();
    s_hi <= RDC_LVL_HIGH;
    s_lo <= RDC_LVL_LOW;
    do_reset();
    host_u.step(1'b0, 1'b1, 1'b0, junk);
    put({RDC_ADDR_BASE, 1'b0}, 1'b1);
    host_u.step(1'b1, 1'b0, 1'b1, junk);
    dev = RDC_ADDR_BASE + 7'h2;
    rd(RDC_OFS_GENERAL, RDC_GEN_RESET);
    $display("t_addr done");
  endtask : t_addr
  initial begin
    core_clk = 1'b0;
    resetn = 1'b0;
    s_hi = RDC_LVL_FLOAT;
    s_lo = RDC_LVL_FLOAT;
    post = 2'b00;
    pre = 2'b00;
    dev = RDC_ADDR_BASE;
    do_reset();
    t_reset();
    t_general();
    t_eq();
    t_addr();
    finish_test();
  end
  // hang guard
  initial begin
    repeat (40000) @(posedge core_clk);
    mismatches++;
    finish_test();
  end
endmodule : rdc_general_ctrl_test
`default_nettype wire
